// ---- inc/pmc_pkg.sv ----
package pmc_pkg;

  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
  localparam logic [7:0] MEM_CFG_ADDR = 8'haf;
  localparam logic [7:0] SP_LOW_ADDR = 8'h81;
  localparam logic [7:0] SP_HIGH_ADDR = 8'hb7;

  localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
  localparam logic [7:0] MEM_CFG_RESET = 8'h00;
  localparam logic [7:0] SP_LOW_RESET = 8'h07;
  localparam logic [2:0] SP_HIGH_RESET = 3'h0;

  localparam int BAUD_DOUBLE_BIT = 7;
  localparam int SERIAL_WAKE_BIT = 6;
  localparam int EXT0_WAKE_BIT = 5;
  localparam int ALE_SUPPRESS_BIT = 4;
  localparam int USER_FLAG1_BIT = 3;
  localparam int USER_FLAG0_BIT = 2;
  localparam int POWER_DOWN_BIT = 1;
  localparam int EXT_STACK_BIT = 7;
  localparam int ONCHIP_EXT_RAM_EN_BIT = 0;

  localparam logic [7:0] PWR_CTRL_MASK = 8'hfe;
  localparam logic [7:0] MEM_CFG_MASK = 8'h81;

  localparam int SP_HIGH_W = 3;
  localparam int DATA_POINTER_W = 24;
  localparam logic [23:0] ONCHIP_EXT_RAM_TOP = 24'h0007ff;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmc_sfr_req_t;

  typedef struct packed {
    logic push;
    logic pop;
  } pmc_stack_op_t;

endpackage : pmc_pkg

// ---- hw/pmc_wake.sv ----
`timescale 1ns/1ps
// wake decision; pin already synchronised by the caller
module pmc_wake
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_irq,
  input wire logic ext_pin_s,
  input wire logic edge_sel,
  input wire logic serial_en,
  input wire logic ext_en,
  output logic wake
);

  logic pin_prev_q;
  logic fall;
  logic ext_hit;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_prev_q <= 1'b1;
    else
      pin_prev_q <= ext_pin_s;
  end

  assign fall = pin_prev_q & ~ext_pin_s;
  assign ext_hit = edge_sel ? fall : ~ext_pin_s; // see R3
  assign wake = (serial_en & serial_irq) | (ext_en & ext_hit); // see R2, R16

endmodule : pmc_wake

// ---- hw/pmc_stack.sv ----
`timescale 1ns/1ps
module pmc_stack
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_en,
  input wire pmc_pkg::pmc_stack_op_t op,
  input wire logic ld_low,
  input wire logic ld_high,
  input wire logic [7:0] wdata,
  output logic [7:0] sp_low,
  output logic [pmc_pkg::SP_HIGH_W-1:0] sp_high
);

  logic [10:0] sp_q;
  logic [10:0] sp_d;
  logic [10:0] inc;
  logic [10:0] dec;

  // carry into the high part only in extended mode; otherwise 8-bit wrap
  function automatic logic [10:0] step(input logic [10:0] v, input logic up,
                                       input logic ext);
    logic [10:0] r;
    r = up ? v + 11'h001 : v - 11'h001;
    if (!ext)
      r = {v[10:8], r[7:0]}; // see R10
    return r; // see R9
  endfunction : step

  assign inc = step(sp_q, 1'b1, ext_en);
  assign dec = step(sp_q, 1'b0, ext_en);

  always_comb
  begin
    sp_d = sp_q;
    if (op.push)
      sp_d = inc;
    else if (op.pop)
      sp_d = dec;
    if (ld_low)
      sp_d[7:0] = wdata;
    if (ld_high && ext_en) // see R15
      sp_d[10:8] = wdata[2:0]; // see R14
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sp_q <= {pmc_pkg::SP_HIGH_RESET, pmc_pkg::SP_LOW_RESET};
    else
      sp_q <= sp_d;
  end

  assign sp_low = sp_q[7:0];
  assign sp_high = ext_en ? sp_q[10:8] : 3'h0; // see R9

endmodule : pmc_stack

// ---- hw/pmc_regs.sv ----
`timescale 1ns/1ps
//Function
// R1 - baud double bit doubles UART rate
// R2 - serial wake bit lets SPI/I2C wake
// R3 - ext0 wake: level or falling edge
// R4 - suppress bit disables address latch output
// R5 - two user flags, no hardware effect
// R6 - power-down bit enters power-down
// R7 - unimplemented bits ignore writes
// R8 - config register resets to 00H
// R9 - extended stack carries 00FFH to 0100H
// R10 - without extension stack wraps FFH to 00H
// R11 - ONCHIP_EXT_RAM enable maps low 2 kbytes on-chip
// R12 - ONCHIP_EXT_RAM disabled: all accesses go external
// R13 - pointer above 0007FFH always external
// R14 - stack high holds three extra bits
// R15 - stack high locked while extension off
// R16 - wake only from enabled sources
module pmc_regs
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  input wire logic STACK_PUSH,
  input wire logic STACK_POP,
  input wire logic XMEM_REQ,
  input wire logic [23:0] DATA_POINTER,
  input wire logic SERIAL_IRQ,
  input wire logic EXT_IRQ0_PIN,
  input wire logic EXT_IRQ0_EDGE_SELECT,
  output logic BAUD_DOUBLE,
  output logic ADDR_LATCH_ENABLE_OUT,
  output logic POWER_DOWN,
  output logic ONCHIP_EXT_RAM_SELECT,
  output logic EXT_BUS_SELECT,
  output logic [10:0] STACK_POINTER
);

  pmc_pkg::pmc_sfr_req_t req;
  pmc_pkg::pmc_stack_op_t sop;

  logic [7:0] pwr_q;
  logic [7:0] cfg_q;
  logic pd_q;
  logic pd_d;
  logic pin_meta_q;
  logic pin_sync_q;
  logic wake;
  logic ext_stack;
  logic onchip_ext_ram_en;
  logic wr_pwr;
  logic wr_cfg;
  logic wr_spl;
  logic wr_sph;
  logic [7:0] sp_low;
  logic [2:0] sp_high;
  logic in_onchip_ext_ram;
  logic [7:0] rdata_d;
  logic hit_d;
  logic [7:0] sph_read;

  assign req = '{wr: SFR_WR, rd: SFR_RD, addr: SFR_ADDR, wdata: SFR_WDATA};
  assign sop = '{push: STACK_PUSH, pop: STACK_POP};

  assign wr_pwr = req.wr && req.addr == pmc_pkg::PWR_CTRL_ADDR;
  assign wr_cfg = req.wr && req.addr == pmc_pkg::MEM_CFG_ADDR;
  assign wr_spl = req.wr && req.addr == pmc_pkg::SP_LOW_ADDR;
  assign wr_sph = req.wr && req.addr == pmc_pkg::SP_HIGH_ADDR;

  assign ext_stack = cfg_q[pmc_pkg::EXT_STACK_BIT];
  assign onchip_ext_ram_en = cfg_q[pmc_pkg::ONCHIP_EXT_RAM_EN_BIT];

  // unimplemented positions are never stored, so they read back zero
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pwr_q <= pmc_pkg::PWR_CTRL_RESET;
      cfg_q <= pmc_pkg::MEM_CFG_RESET; // see R8
    end
    else
    begin
      if (wr_pwr)
        pwr_q <= req.wdata & pmc_pkg::PWR_CTRL_MASK; // see R5, R7
      if (wr_cfg)
        cfg_q <= req.wdata & pmc_pkg::MEM_CFG_MASK; // see R7
    end
  end

  // pin comes from outside the clock domain
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end
    else
    begin
      pin_meta_q <= EXT_IRQ0_PIN;
      pin_sync_q <= pin_meta_q;
    end
  end

  pmc_wake u_wake
  (
    .clk(MCLK),
    .rst_n(RESET_N),
    .serial_irq(SERIAL_IRQ),
    .ext_pin_s(pin_sync_q),
    .edge_sel(EXT_IRQ0_EDGE_SELECT),
    .serial_en(pwr_q[pmc_pkg::SERIAL_WAKE_BIT]),
    .ext_en(pwr_q[pmc_pkg::EXT0_WAKE_BIT]),
    .wake(wake)
  );

  // a write of 1 enters power-down; wake ends it; wake wins a same-cycle write
  assign pd_d = wake ? 1'b0 : // see R16
                (wr_pwr && req.wdata[pmc_pkg::POWER_DOWN_BIT]) ? 1'b1 : pd_q; // see R6

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      pd_q <= 1'b0;
    else
      pd_q <= pd_d;
  end

  pmc_stack u_stack
  (
    .clk(MCLK),
    .rst_n(RESET_N),
    .ext_en(ext_stack),
    .op(sop),
    .ld_low(wr_spl),
    .ld_high(wr_sph),
    .wdata(req.wdata),
    .sp_low(sp_low),
    .sp_high(sp_high)
  );

  assign in_onchip_ext_ram = onchip_ext_ram_en && DATA_POINTER <= pmc_pkg::ONCHIP_EXT_RAM_TOP; // see R11, R13

  assign sph_read = ext_stack ? {5'h00, sp_high} : 8'h00; // see R15

  always_comb
  begin
    rdata_d = 8'h00;
    hit_d = 1'b1;
    unique case (req.addr)
      pmc_pkg::PWR_CTRL_ADDR: rdata_d = {pwr_q[7:2], pd_q, 1'b0};
      pmc_pkg::MEM_CFG_ADDR: rdata_d = cfg_q;
      pmc_pkg::SP_LOW_ADDR: rdata_d = sp_low;
      pmc_pkg::SP_HIGH_ADDR: rdata_d = sph_read;
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      SFR_RDATA <= 8'h00;
      SFR_HIT <= 1'b0;
      BAUD_DOUBLE <= 1'b0;
      ADDR_LATCH_ENABLE_OUT <= 1'b0;
      POWER_DOWN <= 1'b0;
      ONCHIP_EXT_RAM_SELECT <= 1'b0;
      EXT_BUS_SELECT <= 1'b0;
      STACK_POINTER <= {pmc_pkg::SP_HIGH_RESET, pmc_pkg::SP_LOW_RESET};
    end
    else
    begin
      SFR_RDATA <= req.rd ? rdata_d : 8'h00;
      SFR_HIT <= req.rd & hit_d;
      BAUD_DOUBLE <= pwr_q[pmc_pkg::BAUD_DOUBLE_BIT]; // see R1
      ADDR_LATCH_ENABLE_OUT <= ~pwr_q[pmc_pkg::ALE_SUPPRESS_BIT]; // see R4
      POWER_DOWN <= pd_d; // see R6
      ONCHIP_EXT_RAM_SELECT <= XMEM_REQ & in_onchip_ext_ram; // see R11
      EXT_BUS_SELECT <= XMEM_REQ & ~in_onchip_ext_ram; // see R12, R13
      STACK_POINTER <= {sp_high, sp_low};
    end
  end

endmodule : pmc_regs

// ---- bench/pmc_regs_assertions.sv ----
`timescale 1ns/1ps
module pmc_checker
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  input wire logic XMEM_REQ,
  input wire logic [23:0] DATA_POINTER,
  input wire logic SERIAL_IRQ,
  input wire logic BAUD_DOUBLE,
  input wire logic ADDR_LATCH_ENABLE_OUT,
  input wire logic POWER_DOWN,
  input wire logic ONCHIP_EXT_RAM_SELECT,
  input wire logic EXT_BUS_SELECT
);
  logic [7:0] pc_q;
  logic [7:0] mc_q;
  wire logic wr_pc = SFR_WR && SFR_ADDR == pmc_pkg::PWR_CTRL_ADDR;
  wire logic hit_x = mc_q[0] && DATA_POINTER <= pmc_pkg::ONCHIP_EXT_RAM_TOP;
  // shadows of the last written bytes, used as wake and map enables
  always_ff @(posedge MCLK or negedge RESET_N)
    if (!RESET_N)
      pc_q <= 8'h00;
    else if (wr_pc)
      pc_q <= SFR_WDATA;
  always_ff @(posedge MCLK or negedge RESET_N)
    if (!RESET_N)
      mc_q <= 8'h00;
    else if (SFR_WR && SFR_ADDR == pmc_pkg::MEM_CFG_ADDR)
      mc_q <= SFR_WDATA;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  baud_follow_a: assert property (wr_pc |-> ##2 BAUD_DOUBLE == $past(SFR_WDATA[7], 2))
    else $error("baud double mismatch");
  latch_off_a: assert property (wr_pc |-> ##2 ADDR_LATCH_ENABLE_OUT != $past(SFR_WDATA[4], 2))
    else $error("latch enable mismatch");
  dn_enter_a: assert property (wr_pc && SFR_WDATA[1] && SFR_WDATA[6:5] == 2'b00 |-> ##2 POWER_DOWN)
    else $error("power down not entered");
  serial_wake_a: assert property (POWER_DOWN && SERIAL_IRQ && pc_q[6] |-> ##[1:3] !POWER_DOWN)
    else $error("serial wake missed");
  no_wake_a: assert property (POWER_DOWN && pc_q[6:5] == 2'b00
    && !SFR_WR && !$past(SFR_WR) |=> POWER_DOWN) else $error("wake from disabled source");
  onchip_ext_ram_map_a: assert property (XMEM_REQ && hit_x |=> ONCHIP_EXT_RAM_SELECT && !EXT_BUS_SELECT)
    else $error("on-chip select wrong");
  ext_map_a: assert property (XMEM_REQ && !hit_x |=> EXT_BUS_SELECT && !ONCHIP_EXT_RAM_SELECT)
    else $error("external select wrong");
  cfg_read_a: assert property (SFR_RD && SFR_ADDR == pmc_pkg::MEM_CFG_ADDR && !SFR_WR
    |=> SFR_RDATA == (mc_q & pmc_pkg::MEM_CFG_MASK)) else $error("config readback");
  cover property (wr_pc && SFR_WDATA[1]);
  cover property (POWER_DOWN && SERIAL_IRQ);
  cover property (XMEM_REQ && ONCHIP_EXT_RAM_SELECT);
endmodule : pmc_checker
bind pmc_regs pmc_checker u_chk (.*);

// ---- bench/power_memory_config_regs_bench.sv ----
`timescale 1ns/1ps
module power_memory_config_regs_bench;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic wr = 1'b0, rd = 1'b0, push = 1'b0, pop = 1'b0, xreq = 1'b0;
  logic sirq = 1'b0, pin = 1'b1, esel = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [23:0] dp = 24'h000000;
  logic hit, baud, latch, dn, xsel, ebus;
  logic [10:0] stk;
  int compares = 0, miscompares = 0, cycles = 0;
  pmc_regs u_dut
  (
    .MCLK(mclk), .RESET_N(reset_n), .SFR_WR(wr), .SFR_RD(rd), .SFR_ADDR(addr),
    .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SFR_HIT(hit), .STACK_PUSH(push),
    .STACK_POP(pop), .XMEM_REQ(xreq), .DATA_POINTER(dp), .SERIAL_IRQ(sirq),
    .EXT_IRQ0_PIN(pin), .EXT_IRQ0_EDGE_SELECT(esel), .BAUD_DOUBLE(baud),
    .ADDR_LATCH_ENABLE_OUT(latch), .POWER_DOWN(dn), .ONCHIP_EXT_RAM_SELECT(xsel),
    .EXT_BUS_SELECT(ebus), .STACK_POINTER(stk)
  );
  always #25 mclk = ~mclk;
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  always @(posedge mclk)
  begin
    cycles++;
    // the whole sequence needs well under a hundred cycles
    if (cycles == 3000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk);
    wr = 1'b0;
  endtask : put
  task automatic get(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    rd = 1'b1;
    addr = a;
    @(negedge mclk);
    rd = 1'b0;
    chk(rdata, exp);
    chk(hit, 1'b1);
  endtask : get
  task automatic wait_dn(input logic e);
    repeat (8)
      if (dn !== e)
        @(negedge mclk);
    chk(dn, e);
  endtask : wait_dn
  task automatic step(input int n);
    repeat (n)
      @(negedge mclk);
  endtask : step
  initial
  begin
    step(5);
    reset_n = 1'b1;
    get(8'haf, 8'h00);
    put(8'h87, 8'hff);
    get(8'h87, 8'hfe);
    chk({baud, latch}, 2'b10);
    wait_dn(1'b1);
    sirq = 1'b1;
    wait_dn(1'b0);
    sirq = 1'b0;
    put(8'h87, 8'h0e);
    sirq = 1'b1;
    pin = 1'b0;
    step(6);
    chk(dn, 1'b1);
    sirq = 1'b0;
    get(8'h87, 8'h0e);
    put(8'h87, 8'h22);
    wait_dn(1'b0);
    esel = 1'b1;
    put(8'h87, 8'h22);
    step(6);
    chk(dn, 1'b1);
    pin = 1'b1;
    step(4);
    pin = 1'b0;
    wait_dn(1'b0);
    $display("power test done");
    put(8'haf, 8'hff);
    get(8'haf, 8'h81);
    xreq = 1'b1;
    dp = 24'h0007ff;
    step(1);
    chk({xsel, ebus}, 2'b10);
    dp = 24'h000800;
    step(1);
    chk({xsel, ebus}, 2'b01);
    put(8'h81, 8'hff);
    put(8'hb7, 8'h00);
    push = 1'b1;
    step(1);
    push = 1'b0;
    step(1);
    chk(stk, 11'h100);
    get(8'hb7, 8'h01);
    put(8'haf, 8'h00);
    dp = 24'h000000;
    step(1);
    chk({xsel, ebus}, 2'b01);
    xreq = 1'b0;
    $display("memory map test done");
    get(8'hb7, 8'h00);
    put(8'hb7, 8'h07);
    put(8'h81, 8'hff);
    push = 1'b1;
    step(1);
    push = 1'b0;
    step(1);
    chk(stk, 11'h000);
    put(8'haf, 8'h80);
    get(8'hb7, 8'h01);
    // pop back across the byte boundary: 0100h must borrow to 00ffh
    pop = 1'b1;
    step(1);
    pop = 1'b0;
    step(1);
    chk(stk, 11'h0ff);
    $display("stack test done");
    wrap_up();
  end
endmodule : power_memory_config_regs_bench
